// ==== read_freeze_tracker.v ====
// ----------------------------------------
// read freeze tracker
// ----------------------------------------
// arm sets one pending bit per upper-byte register; each read clears its bit
module read_freeze_tracker #(
	parameter N = 2
) (
	input wire clock,
	input wire rst,
	input wire arm,
	input wire [N-1:0] clear,
	output wire frozen
);

	reg [N-1:0] pending_reg;

	// arm wins over a clear in the same cycle so no freeze is lost
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pending_reg <= {N{1'b0}};
		end else if (arm) begin
			pending_reg <= {N{1'b1}}; // [RL13] [RL14]
		end else begin
			pending_reg <= pending_reg & ~clear; // [RL20]
		end
	end

	assign frozen = |pending_reg;

endmodule

// ==== reg_host.sv ====
// ----------------------------------------
// register host model
// ----------------------------------------
module reg_host (
	input wire clock,
	input wire [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus values
	initial begin
		reg_addr = 8'hff;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// one-cycle write; released lines show inverted values, not stale ones
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = (a == 8'h10) ? (d & 8'hcf) : (a == 8'h11) ? (d & 8'h01) : d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask

	// one-cycle read, data taken the cycle after the strobe
	task rd(input [7:0] a, output [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clock);
		reg_read = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ==== temperature_encoder.v ====
`include "thermal_fan_map.vh"

// ----------------------------------------
// temperature result encoder
// ----------------------------------------
// raw is signed, quarter-degree units; upper byte plus two fraction bits out
module temperature_encoder (
	input wire [9:0] raw,
	input wire twos_format,
	input wire diode_fault,
	output reg [7:0] upper,
	output reg [1:0] frac
);

	reg [9:0] shifted;

	// fault codes first, then format; below -64 degrees offset form clamps
	always @* begin
		shifted = raw + `OFFSET64_ADD;
		if (diode_fault) begin
			upper = twos_format ? `FAULT_TWOS : `FAULT_OFFSET64; // [RL17] [RL18]
			frac = 2'h0;
		end else if (twos_format) begin
			{upper, frac} = raw; // [RL16]
		end else if (raw[9] && !raw[8]) begin
			upper = 8'h00; // clamp, would otherwise wrap to a hot reading
			frac = 2'h0;
		end else begin
			{upper, frac} = shifted; // [RL16]
		end
	end

endmodule

// ==== testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst = 1, conv_valid = 0, standby_power = 0, alert_enable = 1;
	logic manual_mode = 0;
	logic [9:0] core_supply_raw = 0, own_supply_raw = 0, remote_one_raw = 0;
	logic [9:0] local_raw = 0, remote_two_raw = 0;
	logic [2:0] diode_fault = 0;
	logic [7:0] core_low_limit = 8'h80, overtemp_limit = 8'h30, v;
	logic [3:0] overtemp_hysteresis = 4'h4;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire [2:0] fan_slow_x4;
	wire reg_write, reg_read, extra_smoothing_enable, overtemp_signal, fan_overtemp_override;
	wire core_supply_low_status_set, smbalert_request, processor_hot_monitor;
	wire fan_spinup_request, monitoring_start, fans_full_speed, temperature_format_select;
	wire overtemp_hysteresis_disable, config_locked;
	int error_cnt = 0, tests_run = 0, n_low = 0, n_spin = 0;

	// ----------------------------------------
	// clock, design and host
	// ----------------------------------------
	always #10 clock = ~clock;
	// pulses are counted here so a one-cycle event is never missed
	always @(posedge clock) begin
		n_low <= n_low + core_supply_low_status_set;
		n_spin <= n_spin + fan_spinup_request;
	end
	thermal_fan_config_readout dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .conv_valid, .core_supply_raw, .own_supply_raw,
		.remote_one_raw, .local_raw, .remote_two_raw, .diode_fault, .standby_power,
		.core_low_limit, .alert_enable, .manual_mode, .overtemp_limit,
		.overtemp_hysteresis, .fan_slow_x4, .extra_smoothing_enable, .overtemp_signal,
		.fan_overtemp_override, .core_supply_low_status_set, .smbalert_request,
		.processor_hot_monitor, .fan_spinup_request, .monitoring_start, .fans_full_speed,
		.temperature_format_select, .overtemp_hysteresis_disable, .config_locked);
	reg_host h (.clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input [7:0] got, input [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task flag(input logic f, input logic e);
		chk({7'h0, f}, {7'h0, e});
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		h.rd(a, v);
		chk(v, e);
	endtask
	// extra cycle lets registered outputs follow the write
	task wrs(input [7:0] a, input [7:0] d);
		h.wr(a, d);
		@(negedge clock);
	endtask
	task conv;
		@(negedge clock);
		conv_valid = 1'b1;
		@(negedge clock);
		conv_valid = 1'b0;
		repeat (2) @(negedge clock);
	endtask
	task close_out;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		for (int i = 0; i < 3; i++) rdc(8'(8'h25 + i), 8'h80);
		rdc(8'h21, 8'h00);
		rdc(8'h22, 8'h00);
		rdc(8'h10, 8'h00);
		rdc(8'h11, 8'h00);
		flag(temperature_format_select, 1'b1);
	endtask
	task t_cfg;
		for (int i = 0; i < 3; i++) begin
			wrs(8'h10, 8'(1 << i));
			chk({5'h0, fan_slow_x4}, 8'(1 << i));
		end
		wrs(8'h10, 8'h87);
		flag(extra_smoothing_enable, 1'b1);
		rdc(8'h10, 8'h87);
		wrs(8'h11, 8'hff);
		flag(overtemp_hysteresis_disable, 1'b1);
		rdc(8'h11, 8'h01);
		h.wr(8'h21, 8'h55);
		rdc(8'h21, 8'h00);
	endtask
	task t_fmt;
		remote_one_raw = 10'h065;
		local_raw = 10'h3d8;
		diode_fault = 3'b100;
		conv;
		rdc(8'h25, 8'h19);
		rdc(8'h26, 8'hf6);
		rdc(8'h27, 8'h80);
		wrs(8'h7c, 8'h00);
		flag(temperature_format_select, 1'b0);
		conv;
		rdc(8'h25, 8'h59);
		rdc(8'h26, 8'h36);
		rdc(8'h27, 8'h00);
		local_raw = 10'h2c0;
		conv;
		rdc(8'h26, 8'h00);
		local_raw = 10'h3d8;
		wrs(8'h7c, 8'h01);
		conv;
	endtask
	// host reads the extended register first for full resolution
	task t_freeze;
		core_supply_raw = {8'h5a, 2'b11};
		own_supply_raw = {8'h33, 2'b01};
		conv;
		rdc(8'h76, 8'h1c);
		core_supply_raw = {8'ha5, 2'b00};
		own_supply_raw = {8'hc3, 2'b00};
		conv;
		rdc(8'h21, 8'h5a);
		rdc(8'h22, 8'h33);
		conv;
		rdc(8'h21, 8'ha5);
		rdc(8'h77, 8'h04);
		remote_one_raw = 10'h0c8;
		conv;
		rdc(8'h25, 8'h19);
		rdc(8'h26, 8'hf6);
		rdc(8'h27, 8'h80);
		conv;
		rdc(8'h25, 8'h32);
	endtask
	task t_ovt;
		flag(fan_overtemp_override, 1'b1);
		flag(overtemp_signal, 1'b1);
		diode_fault = 3'b111;
		conv;
		flag(fan_overtemp_override, 1'b0);
		rdc(8'h25, 8'h80);
		diode_fault = 3'b100;
		conv;
		flag(fan_overtemp_override, 1'b1);
		manual_mode = 1'b1;
		conv;
		flag(overtemp_signal, 1'b0);
		flag(fan_overtemp_override, 1'b1);
		wrs(8'h10, 8'h8f);
		conv;
		flag(overtemp_signal, 1'b1);
		remote_one_raw = 10'h0c0;
		conv;
		flag(fan_overtemp_override, 1'b0);
		manual_mode = 1'b0;
	endtask
	task t_low;
		wrs(8'h10, 8'h48);
		standby_power = 1'b1;
		flag(processor_hot_monitor, 1'b1);
		core_supply_raw = {8'h40, 2'b00};
		conv;
		chk(8'(n_low), 8'h01);
		flag(processor_hot_monitor, 1'b0);
		flag(smbalert_request, 1'b1);
		core_supply_raw = {8'h90, 2'b00};
		conv;
		@(negedge clock);
		chk(8'(n_spin), 8'h01);
		flag(processor_hot_monitor, 1'b1);
	endtask
	task t_lock;
		wrs(8'h40, 8'h02);
		flag(config_locked, 1'b1);
		h.wr(8'h10, 8'h00);
		h.wr(8'h11, 8'h00);
		rdc(8'h10, 8'h48);
		rdc(8'h11, 8'h01);
		h.wr(8'h7c, 8'h00);
		flag(temperature_format_select, 1'b1);
		wrs(8'h40, 8'h09);
		flag(config_locked, 1'b1);
		flag(monitoring_start, 1'b1);
		flag(fans_full_speed, 1'b1);
		rdc(8'h40, 8'h0f);
	endtask

	// main sequence after a 20-cycle reset
	initial begin
		repeat (20) @(negedge clock);
		rst = 1'b0;
		t_reset;
		t_cfg;
		t_fmt;
		t_freeze;
		t_ovt;
		t_low;
		t_lock;
		close_out;
	end
	// watchdog, well beyond the 190 or so cycles the scenarios need
	initial begin
		#200000;
		error_cnt++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		close_out;
	end
endmodule

// ==== tfc_checker.sv ====
// ----------------------------------------
// port checker for the config/readout block
// ----------------------------------------
module tfc_checker (
	input wire clock,
	input wire rst,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire conv_valid,
	input wire [2:0] diode_fault,
	input wire alert_enable,
	input wire manual_mode,
	input wire [2:0] fan_slow_x4,
	input wire extra_smoothing_enable,
	input wire overtemp_signal,
	input wire fan_overtemp_override,
	input wire core_supply_low_status_set,
	input wire smbalert_request,
	input wire processor_hot_monitor,
	input wire fan_spinup_request,
	input wire overtemp_hysteresis_disable,
	input wire config_locked
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// entry and exit steps of the core-low condition
	sequence s_enter;
		core_supply_low_status_set;
	endsequence
	sequence s_low_on;
		!core_supply_low_status_set && !processor_hot_monitor;
	endsequence
	sequence s_recover;
		fan_spinup_request;
	endsequence

	property p_low_off;
		s_enter |=> s_low_on;
	endproperty
	a_low_off: assert property (p_low_off) else $error("monitor still on after core low");
	property p_alert;
		s_enter and alert_enable |=> smbalert_request;
	endproperty
	a_alert: assert property (p_alert) else $error("alert missing after core low");
	property p_recover;
		s_recover |=> processor_hot_monitor && !fan_spinup_request;
	endproperty
	a_recover: assert property (p_recover) else $error("monitor not back after recovery");
	// override is the wider condition, output only adds the manual gate
	property p_override;
		overtemp_signal |-> fan_overtemp_override;
	endproperty
	a_override: assert property (p_override) else $error("overtemp output without override");
	property p_auto;
		fan_overtemp_override && !$past(manual_mode) |-> overtemp_signal;
	endproperty
	a_auto: assert property (p_auto) else $error("overtemp output lost in auto mode");
	property p_fault;
		conv_valid && (&diode_fault) |=> ##1 !fan_overtemp_override;
	endproperty
	a_fault: assert property (p_fault) else $error("faulted channels raised override");
	property p_lock_once;
		config_locked |=> config_locked;
	endproperty
	a_lock_once: assert property (p_lock_once) else $error("lock bit cleared");
	property p_locked_cfg;
		config_locked && $past(config_locked) |=> $stable(fan_slow_x4)
			&& $stable(extra_smoothing_enable) && $stable(overtemp_hysteresis_disable);
	endproperty
	a_locked_cfg: assert property (p_locked_cfg) else $error("config changed while locked");
	property p_rdata;
		!$past(reg_read) |-> $stable(reg_rdata);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved without a read");
endmodule

bind thermal_fan_config_readout tfc_checker chk (.clock, .rst, .reg_read, .reg_rdata,
	.conv_valid, .diode_fault, .alert_enable, .manual_mode, .fan_slow_x4,
	.extra_smoothing_enable, .overtemp_signal, .fan_overtemp_override,
	.core_supply_low_status_set, .smbalert_request, .processor_hot_monitor,
	.fan_spinup_request, .overtemp_hysteresis_disable, .config_locked);

// ==== thermal_fan_config_readout.v ====
// Overview of operation
// [RL1] slow bit 0 multiplies fan 1 smoothing by four
// [RL2] slow bit 1 multiplies fan 2 smoothing by four
// [RL3] slow bit 2 multiplies fan 3 smoothing by four
// [RL4] bit 3 keeps overtemp output active in manual
// [RL5] host leaves reserved config bits unwritten
// [RL6] core supply low on standby: status, alert, monitor off
// [RL7] supply recovered: monitor back on, fan spin-up
// [RL8] extra slow lengthens all smoothing by 39.2 percent
// [RL9] overtemp event overrides every fan setting
// [RL10] lock makes both config registers read-only
// [RL11] hysteresis disable bit removes overtemp hysteresis
// [RL12] supply upper bytes read-only at 0x21, 0x22
// [RL13] extended voltage read freezes until uppers read
// [RL14] extended temperature read freezes until uppers read
// [RL15] temperature uppers read-only, power-on value 0x80
// [RL16] format bit picks twos complement or offset 64
// [RL17] twos format reports 0x80 on diode fault
// [RL18] offset format reports 0x00 on diode fault
// [RL19] write-once lock bit freezes lockable registers
// [RL20] reading frozen uppers releases the freeze
`include "thermal_fan_map.vh"

module thermal_fan_config_readout (
	input wire clock,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output wire [7:0] reg_rdata,
	input wire conv_valid,
	input wire [9:0] core_supply_raw,
	input wire [9:0] own_supply_raw,
	input wire [9:0] remote_one_raw,
	input wire [9:0] local_raw,
	input wire [9:0] remote_two_raw,
	input wire [2:0] diode_fault,
	input wire standby_power,
	input wire [7:0] core_low_limit,
	input wire alert_enable,
	input wire manual_mode,
	input wire [7:0] overtemp_limit,
	input wire [3:0] overtemp_hysteresis,
	output wire [2:0] fan_slow_x4,
	output wire extra_smoothing_enable,
	output wire overtemp_signal,
	output wire fan_overtemp_override,
	output wire core_supply_low_status_set,
	output wire smbalert_request,
	output wire processor_hot_monitor,
	output wire fan_spinup_request,
	output wire monitoring_start,
	output wire fans_full_speed,
	output wire temperature_format_select,
	output wire overtemp_hysteresis_disable,
	output wire config_locked
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// map a reading to an unsigned scale so one compare serves both formats
	function [8:0] to_unsigned;
		input [7:0] value;
		input twos;
		begin
			if (twos) begin
				to_unsigned = {1'b0, ~value[7], value[6:0]};
			end else begin
				to_unsigned = {1'b0, value};
			end
		end
	endfunction

	// next overtemp state of one channel with optional hysteresis
	function overtemp_next;
		input state;
		input [8:0] temp_u;
		input [8:0] limit_u;
		input [3:0] hyst;
		input hys_off;
		input fault;
		reg [8:0] release_u;
		begin
			release_u = (limit_u > {5'h00, hyst}) ? limit_u - {5'h00, hyst} : 9'h000;
			if (fault) begin
				overtemp_next = 1'b0;
			end else if (temp_u > limit_u) begin
				overtemp_next = 1'b1;
			end else if (hys_off) begin
				overtemp_next = 1'b0; // [RL11]
			end else if (temp_u < release_u) begin
				overtemp_next = 1'b0;
			end else begin
				overtemp_next = state;
			end
		end
	endfunction

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg [7:0] cfg1_reg;
	reg [7:0] cfg5_reg;
	reg [7:0] cfg6_reg;
	reg [7:0] cfg7_reg;
	reg [7:0] core_supply_reg;
	reg [7:0] own_supply_reg;
	reg [7:0] ext_volt_reg;
	reg [7:0] ext_temp_reg;
	reg [7:0] temp_reg [0:2];
	reg [7:0] rdata_reg;
	reg [7:0] rdata_next;
	reg [2:0] overtemp_reg;
	reg core_low_reg;
	reg overtemp_signal_reg;
	reg fan_override_reg;
	reg status_set_reg;
	reg smbalert_reg;
	reg hot_monitor_reg;
	reg spinup_reg;

	wire locked;
	wire twos;
	wire [9:0] raw_temp [0:2];
	wire [7:0] enc_upper [0:2];
	wire [1:0] enc_frac [0:2];
	wire volt_frozen;
	wire temp_frozen;
	wire read_ext_volt;
	wire read_ext_temp;
	wire [1:0] volt_clear;
	wire [2:0] temp_clear;
	wire core_low_now;
	wire [2:0] overtemp_new;
	wire [8:0] limit_u;

	assign locked = cfg1_reg[`CFG1_LOCK];
	assign twos = cfg5_reg[`CFG5_FORMAT];
	assign raw_temp[0] = remote_one_raw;
	assign raw_temp[1] = local_raw;
	assign raw_temp[2] = remote_two_raw;

	// ----------------------------------------
	// temperature encoding, one per channel
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : enc
			temperature_encoder u_enc (
				.raw(raw_temp[ch]),
				.twos_format(twos),
				.diode_fault(diode_fault[ch]),
				.upper(enc_upper[ch]),
				.frac(enc_frac[ch])
			);
		end
	endgenerate

	// ----------------------------------------
	// read freeze tracking
	// ----------------------------------------

	// reading an extended register arms its group; upper-byte reads release
	assign read_ext_volt = reg_read && (reg_addr == `ADDR_EXT_VOLT);
	assign read_ext_temp = reg_read && (reg_addr == `ADDR_EXT_TEMP);
	assign volt_clear[0] = reg_read && (reg_addr == `ADDR_CORE_SUPPLY);
	assign volt_clear[1] = reg_read && (reg_addr == `ADDR_OWN_SUPPLY);
	assign temp_clear[0] = reg_read && (reg_addr == `ADDR_REMOTE_ONE);
	assign temp_clear[1] = reg_read && (reg_addr == `ADDR_LOCAL);
	assign temp_clear[2] = reg_read && (reg_addr == `ADDR_REMOTE_TWO);

	read_freeze_tracker #(
		.N(2)
	) u_volt_freeze (
		.clock(clock),
		.rst(rst),
		.arm(read_ext_volt),
		.clear(volt_clear),
		.frozen(volt_frozen)
	);

	read_freeze_tracker #(
		.N(3)
	) u_temp_freeze (
		.clock(clock),
		.rst(rst),
		.arm(read_ext_temp),
		.clear(temp_clear),
		.frozen(temp_frozen)
	);

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------

	// lock is write-once; afterwards only start and full speed may change
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg1_reg <= `RST_CFG1;
			cfg5_reg <= `RST_CFG5;
			cfg6_reg <= `RST_CFG6;
			cfg7_reg <= `RST_CFG7;
		end else if (reg_write) begin
			case (reg_addr)
				`ADDR_CFG1: begin
					if (locked) begin
						cfg1_reg <= (cfg1_reg & ~`CFG1_LOCKED_WMASK) |
							(reg_wdata & `CFG1_LOCKED_WMASK); // [RL19]
					end else begin
						cfg1_reg <= (reg_wdata & `CFG1_WMASK) | `RST_CFG1; // [RL19]
					end
				end
				`ADDR_CFG5: begin
					if (!locked) begin
						cfg5_reg <= reg_wdata & `CFG5_WMASK; // [RL19]
					end
				end
				`ADDR_CFG6: begin
					if (!locked) begin
						cfg6_reg <= reg_wdata & `CFG6_WMASK; // [RL10] [RL5]
					end
				end
				`ADDR_CFG7: begin
					if (!locked) begin
						cfg7_reg <= reg_wdata & `CFG7_WMASK; // [RL10] [RL5]
					end
				end
				default: begin
					cfg1_reg <= cfg1_reg; // read-only or unmapped: ignored
				end
			endcase
		end
	end

	// ----------------------------------------
	// result registers
	// ----------------------------------------

	// a conversion only lands when its group is not held for the host
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			core_supply_reg <= `RST_VOLT;
			own_supply_reg <= `RST_VOLT;
			ext_volt_reg <= `RST_EXT;
		end else if (conv_valid && !volt_frozen) begin
			core_supply_reg <= core_supply_raw[9:2]; // [RL12]
			own_supply_reg <= own_supply_raw[9:2]; // [RL12]
			ext_volt_reg <= {2'h0, own_supply_raw[1:0], core_supply_raw[1:0], 2'h0}; // [RL13]
		end
	end

	// temperature uppers come up at 0x80 until the first conversion
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			temp_reg[0] <= `RST_TEMP; // [RL15]
			temp_reg[1] <= `RST_TEMP; // [RL15]
			temp_reg[2] <= `RST_TEMP; // [RL15]
			ext_temp_reg <= `RST_EXT;
		end else if (conv_valid && !temp_frozen) begin
			temp_reg[0] <= enc_upper[0]; // [RL14]
			temp_reg[1] <= enc_upper[1];
			temp_reg[2] <= enc_upper[2];
			ext_temp_reg <= {enc_frac[2], enc_frac[1], enc_frac[0], 2'h0}; // [RL14]
		end
	end

	// ----------------------------------------
	// register readback
	// ----------------------------------------

	// unmapped addresses read as zero
	always @* begin
		case (reg_addr)
			`ADDR_CFG1: rdata_next = cfg1_reg;
			`ADDR_CFG5: rdata_next = cfg5_reg;
			`ADDR_CFG6: rdata_next = cfg6_reg;
			`ADDR_CFG7: rdata_next = cfg7_reg;
			`ADDR_CORE_SUPPLY: rdata_next = core_supply_reg; // [RL12]
			`ADDR_OWN_SUPPLY: rdata_next = own_supply_reg; // [RL12]
			`ADDR_REMOTE_ONE: rdata_next = temp_reg[0]; // [RL15]
			`ADDR_LOCAL: rdata_next = temp_reg[1]; // [RL15]
			`ADDR_REMOTE_TWO: rdata_next = temp_reg[2]; // [RL15]
			`ADDR_EXT_VOLT: rdata_next = ext_volt_reg;
			`ADDR_EXT_TEMP: rdata_next = ext_temp_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// data is captured with the read strobe and held until the next read
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (reg_read) begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// overtemp comparison
	// ----------------------------------------

	// compares use the live conversion, not the frozen host copy,
	// so protection never waits on a slow host
	assign limit_u = to_unsigned(overtemp_limit, twos);

	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : ovt
			assign overtemp_new[ch] = overtemp_next(overtemp_reg[ch],
				to_unsigned(enc_upper[ch], twos), limit_u, overtemp_hysteresis,
				cfg7_reg[`CFG7_HYS_DIS], diode_fault[ch]); // [RL11]
		end
	endgenerate

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			overtemp_reg <= 3'h0;
		end else if (conv_valid) begin
			overtemp_reg <= overtemp_new;
		end
	end

	// override ignores fan disable; the pin only drops in manual mode
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			fan_override_reg <= 1'b0;
			overtemp_signal_reg <= 1'b0;
		end else begin
			fan_override_reg <= |overtemp_reg; // [RL9]
			overtemp_signal_reg <= (|overtemp_reg) &&
				(!manual_mode || cfg6_reg[`CFG6_OVT_MANUAL]); // [RL4]
		end
	end

	// ----------------------------------------
	// core supply low handling
	// ----------------------------------------
	assign core_low_now = cfg6_reg[`CFG6_CORE_LOW] && standby_power &&
		(core_supply_raw[9:2] < core_low_limit); // [RL6]

	// judged per conversion so a glitch between samples cannot trip it
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			core_low_reg <= 1'b0;
			status_set_reg <= 1'b0;
			spinup_reg <= 1'b0;
			smbalert_reg <= 1'b0;
			hot_monitor_reg <= 1'b1;
		end else begin
			status_set_reg <= 1'b0;
			spinup_reg <= 1'b0;
			if (conv_valid) begin
				core_low_reg <= core_low_now;
				status_set_reg <= core_low_now && !core_low_reg; // [RL6]
				spinup_reg <= !core_low_now && core_low_reg; // [RL7]
			end
			smbalert_reg <= core_low_reg && alert_enable; // [RL6]
			hot_monitor_reg <= !core_low_reg; // [RL6] [RL7]
		end
	end

	// ----------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------
	assign reg_rdata = rdata_reg;
	assign fan_slow_x4 = cfg6_reg[2:0]; // [RL1] [RL2] [RL3]
	assign extra_smoothing_enable = cfg6_reg[`CFG6_EXTRA_SLOW]; // [RL8]
	assign overtemp_signal = overtemp_signal_reg;
	assign fan_overtemp_override = fan_override_reg;
	assign core_supply_low_status_set = status_set_reg;
	assign smbalert_request = smbalert_reg;
	assign processor_hot_monitor = hot_monitor_reg;
	assign fan_spinup_request = spinup_reg;
	assign monitoring_start = cfg1_reg[`CFG1_START];
	assign fans_full_speed = cfg1_reg[`CFG1_FULL_SPEED];
	assign temperature_format_select = cfg5_reg[`CFG5_FORMAT];
	assign overtemp_hysteresis_disable = cfg7_reg[`CFG7_HYS_DIS];
	assign config_locked = cfg1_reg[`CFG1_LOCK];

endmodule

// ==== thermal_fan_map.vh ====
`ifndef THERMAL_FAN_MAP_VH
`define THERMAL_FAN_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CFG6 8'h10
`define ADDR_CFG7 8'h11
`define ADDR_CORE_SUPPLY 8'h21
`define ADDR_OWN_SUPPLY 8'h22
`define ADDR_REMOTE_ONE 8'h25
`define ADDR_LOCAL 8'h26
`define ADDR_REMOTE_TWO 8'h27
`define ADDR_CFG1 8'h40
`define ADDR_EXT_VOLT 8'h76
`define ADDR_EXT_TEMP 8'h77
`define ADDR_CFG5 8'h7c

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CFG1 8'h04
`define RST_CFG5 8'h01
`define RST_CFG6 8'h00
`define RST_CFG7 8'h00
`define RST_VOLT 8'h00
`define RST_TEMP 8'h80
`define RST_EXT 8'h00

// ----------------------------------------
// field positions and write masks
// ----------------------------------------
`define CFG1_START 0
`define CFG1_LOCK 1
`define CFG1_READY 2
`define CFG1_FULL_SPEED 3
`define CFG1_WMASK 8'h7b
`define CFG1_LOCKED_WMASK 8'h09
`define CFG5_FORMAT 0
`define CFG5_WMASK 8'hef
`define CFG6_OVT_MANUAL 3
`define CFG6_CORE_LOW 6
`define CFG6_EXTRA_SLOW 7
`define CFG6_WMASK 8'hcf
`define CFG7_HYS_DIS 0
`define CFG7_WMASK 8'h01

// ----------------------------------------
// temperature codes
// ----------------------------------------
`define FAULT_TWOS 8'h80
`define FAULT_OFFSET64 8'h00
`define OFFSET64_ADD 10'h100

`endif
